// ---- rlqec_regs.vh ----
// Register offsets, field positions, reset values and event codes of the event counters.
`ifndef RLQEC_REGS_VH
`define RLQEC_REGS_VH
`define RLQEC_CTL0_ADDR 8'h00
`define RLQEC_CNT0_ADDR 8'h04
`define RLQEC_CTL_STRIDE 8'h08
`define RLQEC_CREDIT_ADDR 8'h20
`define RLQEC_EVSEL_LSB 0
`define RLQEC_EVSEL_MSB 7
`define RLQEC_UMASK_LSB 8
`define RLQEC_UMASK_MSB 15
`define RLQEC_ENABLE_BIT 22
`define RLQEC_CTL_RESET 32'h00000000
`define RLQEC_CNT_RESET 32'h00000000
`define RLQEC_EV_ING_NONEMPTY 8'h10
`define RLQEC_EV_ING_ALLOC 8'h11
`define RLQEC_EV_ING_OCC 8'h13
`define RLQEC_EV_EGR_NONEMPTY 8'h23
`define RLQEC_EV_EGR_FULL 8'h25
`define RLQEC_EV_NACK_CW 8'h26
`define RLQEC_EV_NACK_CCW 8'h28
`define RLQEC_EV_RSV_USE 8'h36
`define RLQEC_EV_RSV_FAIL 8'h37
`define RLQEC_OCC_MAX_INC 6'h20
`endif

// ---- rlqec.v ----
// Ring-to-link stop event counters with link credit arbitration and an APB register slave.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rlqec_regs.vh"

module rlqec
#(
  parameter NUM_CTR = 3,
  parameter SHARED_CREDITS = 8'h40
)
(
  input wire mclk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [35:0] ingress_occupancy,
  input wire [5:0] ingress_alloc,
  input wire egress_full,
  input wire egress_nonempty,
  input wire [2:0] nack_clockwise,
  input wire [2:0] nack_counterclockwise,
  input wire req_valid,
  input wire [2:0] req_class,
  input wire [3:0] req_flits,
  input wire [3:0] shared_credit_return,
  input wire [5:0] reserved_credit_return,
  output reg req_grant,
  output reg req_grant_reserved,
  output reg req_delayed
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB side.
  //
  // Counter n keeps its control word at 8*n and its count word at 8*n+4.
  // The control word holds the event select in bits 7:0, the unit mask in
  // bits 15:8 and the enable in bit 22; every other bit reads back as zero.
  // The count word is writable, so software may preset or clear it.
  // The word at 0x20 reports the credit pools and is read-only: the reserved
  // bits sit in 13:8 and the shared count in 7:0.
  // Any other address, and any write to the credit word, answers with an
  // error and changes nothing.
  //
  // The slave never stretches an access, so a master that polls pready sees
  // it high in the first access cycle.

  ////////////////////////////////////////////////////////////////////////////
  // Link credit pools.
  //
  // A request with a legal class looks at the shared pool first. It takes from
  // the shared pool only when the whole buffer count fits; otherwise it falls
  // back to the one reserved credit of its own class. A request that finds
  // neither is reported as delayed and is tried again in the next cycle for as
  // long as the master holds it.
  // Classes six and seven name no queue and are always refused, so a stray
  // code can never drain credits that a real class depends on.
  // A request for zero buffers carries no data and never touches the shared
  // pool.

  reg [7:0] shared_credit_pool;
  reg [5:0] reserved_credit_pool;
  wire [5:0] class_hot;
  wire shared_ok;
  wire reserved_ok;
  wire req_live;
  wire take_shared;
  wire take_reserved;
  wire [7:0] shared_take;
  wire [7:0] next_shared;
  wire [5:0] reserved_take;

  // A grant pulse releases the request, so a granted request is never
  // re-evaluated in the cycle after its grant.
  assign req_live = req_valid & ~req_grant;
  assign class_hot = (req_class < 3'h6) ? (6'h01 << req_class) : 6'h00;
  assign shared_ok = (shared_credit_pool >= {4'h0, req_flits}) && (req_flits != 4'h0) &&
    (class_hot != 6'h00);
  assign reserved_ok = |(reserved_credit_pool & class_hot);
  assign take_shared = req_live & shared_ok;
  assign take_reserved = req_live & ~shared_ok & reserved_ok;
  assign shared_take = take_shared ? {4'h0, req_flits} : 8'h00;
  assign reserved_take = take_reserved ? class_hot : 6'h00;
  assign next_shared = shared_credit_pool - shared_take + {4'h0, shared_credit_return};

  always @(posedge mclk)
  begin
    if (srst)
    begin
      shared_credit_pool <= SHARED_CREDITS;
      reserved_credit_pool <= 6'h3F;
      req_grant <= 1'b0;
      req_grant_reserved <= 1'b0;
      req_delayed <= 1'b0;
    end
    else
    begin
      shared_credit_pool <= next_shared;
      // A returned credit and a new take in one cycle leave the credit held.
      reserved_credit_pool <= (reserved_credit_pool & ~reserved_take) | reserved_credit_return;
      req_grant <= take_shared | take_reserved;
      req_grant_reserved <= take_reserved;
      req_delayed <= req_live & ~shared_ok & ~reserved_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared event terms.
  //
  // The credit events reuse the arbitration terms of the same cycle, so a
  // counter counts a use or a refusal at the edge that ends the decision cycle,
  // the same edge at which the grant or delay output shows it.
  // Each class owns one six-bit slice of the occupancy bus.

  wire [5:0] occ [0:5];
  wire [5:0] class_nonempty;
  wire [5:0] rsv_use_hot;
  wire [5:0] rsv_fail_hot;

  assign rsv_use_hot = reserved_take;
  assign rsv_fail_hot = (req_live & ~shared_ok & ~reserved_ok) ? class_hot : 6'h00;

  genvar q;
  generate
    for (q = 0; q < 6; q = q + 1)
    begin : g_class
      assign occ[q] = ingress_occupancy[q*6+5:q*6];
      assign class_nonempty[q] = occ[q] != 6'h00;
    end
  endgenerate

  // Sums the set bits of a six-bit vector.
  function [5:0] pop6;
    input [5:0] v;
    begin
      pop6 = {5'h00, v[0]} + {5'h00, v[1]} + {5'h00, v[2]} + {5'h00, v[3]} +
        {5'h00, v[4]} + {5'h00, v[5]};
    end
  endfunction

  // Entry count of the one queue named by a one-hot mask, clamped to 32.
  function [5:0] occ_pick;
    input [5:0] m;
    input [35:0] all;
    reg [5:0] v;
    begin
      v = 6'h00;
      case (m)
        6'h01: v = all[5:0];
        6'h02: v = all[11:6];
        6'h04: v = all[17:12];
        6'h08: v = all[23:18];
        6'h10: v = all[29:24];
        6'h20: v = all[35:30];
        default: v = 6'h00;
      endcase
      occ_pick = (v > `RLQEC_OCC_MAX_INC) ? `RLQEC_OCC_MAX_INC : v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // General counters.
  //
  // Each counter keeps its control and count words inside its own generate
  // block, so that every word has exactly one writer. The words are gathered
  // into flat vectors for the read mux below.
  // The occupancy term is routed to counter 0 alone, which keeps the wide
  // increment path to one counter. Counters 0 and 1 take the remaining
  // events; counter 2 counts nothing for the events of this block.

  wire [32*NUM_CTR-1:0] ctl_all;
  wire [32*NUM_CTR-1:0] cnt_all;
  wire apb_write;
  wire [7:0] ctr_idx;
  wire [7:0] word_sel;

  assign apb_write = psel & penable & pready & pwrite;
  assign ctr_idx = {3'h0, paddr[7:3]};
  assign word_sel = paddr & 8'h07;

  genvar n;
  generate
    for (n = 0; n < NUM_CTR; n = n + 1)
    begin : g_ctr
      wire [7:0] evsel;
      wire [7:0] umask;
      wire [5:0] m6;
      wire low_pair;
      reg [5:0] inc;
      // Counter n's own words; nothing outside this block writes them.
      reg [31:0] ctl_word;
      reg [31:0] cnt_word;

      assign ctl_all[32*n+31:32*n] = ctl_word;
      assign cnt_all[32*n+31:32*n] = cnt_word;
      assign evsel = ctl_word[`RLQEC_EVSEL_MSB:`RLQEC_EVSEL_LSB];
      assign umask = ctl_word[`RLQEC_UMASK_MSB:`RLQEC_UMASK_LSB];
      assign m6 = umask[5:0];
      assign low_pair = (n < 2);

      always @*
      begin
        inc = 6'h00;
        case (evsel)
          `RLQEC_EV_ING_OCC:
            if (n == 0 && umask[7:6] == 2'b00)
              inc = occ_pick(m6, ingress_occupancy);
          `RLQEC_EV_ING_NONEMPTY:
            if (low_pair)
              inc = {5'h00, |(class_nonempty & m6)};
          `RLQEC_EV_ING_ALLOC:
            if (low_pair)
              inc = pop6(ingress_alloc & m6);
          `RLQEC_EV_EGR_FULL:
            if (low_pair)
              inc = {5'h00, egress_full};
          `RLQEC_EV_EGR_NONEMPTY:
            if (low_pair)
              inc = {5'h00, egress_nonempty};
          `RLQEC_EV_NACK_CCW:
            if (low_pair)
              inc = {5'h00, |(nack_counterclockwise & umask[2:0])};
          `RLQEC_EV_NACK_CW:
            if (low_pair)
              inc = {5'h00, |(nack_clockwise & umask[2:0])};
          `RLQEC_EV_RSV_USE:
            if (low_pair)
              inc = pop6(rsv_use_hot & m6);
          `RLQEC_EV_RSV_FAIL:
            if (low_pair)
              inc = pop6(rsv_fail_hot & m6);
          default:
            inc = 6'h00;
        endcase
      end

      // A software write to the count wins over that cycle's increment.
      always @(posedge mclk)
      begin
        if (srst)
        begin
          ctl_word <= `RLQEC_CTL_RESET;
          cnt_word <= `RLQEC_CNT_RESET;
        end
        else
        begin
          if (apb_write && ctr_idx == n && word_sel == `RLQEC_CTL0_ADDR)
            ctl_word <= pwdata & 32'h0040FFFF;
          if (apb_write && ctr_idx == n && word_sel == `RLQEC_CNT0_ADDR)
            cnt_word <= pwdata;
          else if (ctl_word[`RLQEC_ENABLE_BIT])
            cnt_word <= cnt_word + {26'h0000000, inc};
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access, answer prepared in the setup cycle.
  //
  // The read mux runs during the setup cycle and its result is registered, so
  // prdata, pready and pslverr all come straight from flip-flops and stand for
  // exactly the access cycle. Write data is taken at the end of that cycle,
  // when psel, penable and pready are all high.
  // The limitation is that a count read shows the value before any increment
  // of the setup cycle itself; a busy counter may be one step behind.

  reg [31:0] next_prdata;
  reg next_pslverr;
  integer i;

  always @*
  begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b1;
    for (i = 0; i < NUM_CTR; i = i + 1)
    begin
      if (ctr_idx == i[7:0] && word_sel == `RLQEC_CTL0_ADDR)
      begin
        next_prdata = ctl_all[32*i +: 32];
        next_pslverr = 1'b0;
      end
      if (ctr_idx == i[7:0] && word_sel == `RLQEC_CNT0_ADDR)
      begin
        next_prdata = cnt_all[32*i +: 32];
        next_pslverr = 1'b0;
      end
    end
    if (paddr == `RLQEC_CREDIT_ADDR)
    begin
      next_prdata = {18'h00000, reserved_credit_pool, shared_credit_pool};
      next_pslverr = pwrite;
    end
    if (pwrite)
      next_prdata = 32'h00000000;
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & next_pslverr;
      prdata <= (psel & ~penable) ? next_prdata : 32'h00000000;
    end
  end

endmodule

// ---- rlqec_monitor.sv ----
// Checker of the APB answer and the link credit outputs.
`timescale 1ns/1ps
module rlqec_monitor (
  input wire mclk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire req_valid,
  input wire [2:0] req_class,
  input wire [3:0] req_flits,
  input wire req_grant,
  input wire req_grant_reserved,
  input wire req_delayed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("long answer");
  chk_unmapped_err: assert property (pready && paddr > 8'h20 |-> pslverr)
    else $error("no refusal");
  chk_one_answer: assert property (req_valid && !req_grant && req_class < 3'h6 |=> req_grant ^ req_delayed)
    else $error("bad answer");
  chk_bad_class: assert property (req_valid && !req_grant && req_class > 3'h5 |=> req_delayed && !req_grant)
    else $error("bad class");
  chk_reserved_flag: assert property (req_grant_reserved |-> req_grant)
    else $error("lone flag");
  chk_no_request: assert property (!req_valid |=> !req_grant && !req_delayed)
    else $error("idle answer");
  chk_zero_flits: assert property (req_valid && !req_grant && req_flits == 4'h0 |=> !req_grant || req_grant_reserved)
    else $error("shared use");
  chk_grant_pulse: assert property (req_grant |=> !req_grant)
    else $error("long grant");
endmodule
bind rlqec rlqec_monitor i_mon (.*);

// ---- rlqec_test.sv ----
// Self-checking bench of the event counters and credit arbitration.
`timescale 1ns/1ps
module rlqec_test;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, e, x = 32'hD408;
  logic pready, pslverr, req_grant, req_grant_reserved, req_delayed;
  logic [35:0] ingress_occupancy = 0;
  logic [5:0] ingress_alloc = 0, reserved_credit_return = 0, rs = 6'h3F;
  logic egress_full = 0, egress_nonempty = 0, req_valid = 0;
  logic [2:0] nack_clockwise = 0, nack_counterclockwise = 0, req_class = 0;
  logic [3:0] req_flits = 0, shared_credit_return = 0;
  logic [19:0] tb [10] = '{20'h01301, 20'h01320, 20'h11301, 20'h01004, 20'h1113F,
    20'h12500, 20'h02300, 20'h12605, 20'h02807, 20'h22500};
  int fails = 0, checks = 0, cyc = 0, sh = 64, use_n = 0, fail_n = 0, i;
  rlqec i_dut (.*);
  initial forever #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      give_verdict;
    end
  end
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(string n, logic [31:0] ev, logic [31:0] sv);
    checks++;
    if (sv !== ev)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, ev, sv);
    end
  endtask
  task automatic apb(bit w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    #1;
    while (pready !== 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
    rd = prdata;
    er = pslverr;
    @(posedge mclk);
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic int inc(logic [3:0] c, logic [7:0] v, logic [7:0] u);
    int k, n;
    n = 0;
    for (k = 0; k < 6; k++)
    begin
      if (v == 8'h13 && c == 0 && u[k])
        n = ingress_occupancy[6*k+:6] > 6'h20 ? 32 : ingress_occupancy[6*k+:6];
      if (v == 8'h10 && u[k] && ingress_occupancy[6*k+:6] != 0)
        n = 1;
      if (v == 8'h11)
        n += u[k] & ingress_alloc[k];
    end
    if (v == 8'h25)
      n = egress_full;
    if (v == 8'h23)
      n = egress_nonempty;
    if (v == 8'h26)
      n = |(u[2:0] & nack_clockwise);
    if (v == 8'h28)
      n = |(u[2:0] & nack_counterclockwise);
    return c == 2 ? 0 : n;
  endfunction
  task automatic cnt(logic [3:0] c, logic [7:0] v, logic [7:0] u);
    e = 0;
    apb(1, 8 * c, {16'h0040, u, v});
    apb(1, 8 * c + 4, 0);
    repeat (40)
    begin
      e += inc(c, v, u);
      x = xs(x);
      {ingress_occupancy, ingress_alloc, egress_full, egress_nonempty, nack_clockwise,
        nack_counterclockwise} <= {x[17:0], x};
      @(posedge mclk);
    end
    e += inc(c, v, u);
    {ingress_occupancy, ingress_alloc, egress_full, egress_nonempty, nack_clockwise,
      nack_counterclockwise} <= 0;
    apb(0, 8 * c + 4, 0);
    chk("count", e, rd);
  endtask
  task automatic req(logic [2:0] c, logic [3:0] f);
    bit s, r;
    req_valid <= 1;
    req_class <= c;
    req_flits <= f;
    @(posedge mclk) req_valid <= 0;
    #1;
    s = c < 6 && f != 0 && sh >= f;
    r = !s && c < 6 && rs[c];
    if (s)
      sh -= f;
    if (r)
      rs[c] = 0;
    use_n += r;
    fail_n += c < 6 && !s && !r;
    chk("grant", s | r, req_grant);
    chk("reserved", r, req_grant_reserved);
    chk("delayed", !(s | r), req_delayed);
    @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    apb(0, 8'h00, 0);
    chk("ctl0", 0, rd);
    apb(0, 8'h20, 0);
    chk("credit", 32'h3F40, rd);
    apb(1, 8'h20, 1);
    chk("ro", 1, er);
    apb(0, 8'h30, 0);
    chk("unmapped", 1, er);
    for (i = 0; i < 10; i++)
      cnt(tb[i][19:16], tb[i][15:8], tb[i][7:0]);
    apb(1, 0, 32'h00403F36);
    apb(1, 4, 0);
    apb(1, 8, 32'h00403F37);
    apb(1, 12, 0);
    for (i = 0; i < 7; i++)
      req(i % 6, 9);
    req(0, 0);
    req(0, 1);
    req(0, 2);
    req(1, 9);
    req(7, 1);
    apb(0, 4, 0);
    chk("uses", use_n, rd);
    apb(0, 12, 0);
    chk("fails", fail_n, rd);
    shared_credit_return <= 4'h9;
    reserved_credit_return <= 6'h01;
    @(posedge mclk);
    shared_credit_return <= 0;
    reserved_credit_return <= 0;
    sh += 9;
    rs[0] = 1;
    apb(0, 8'h20, 0);
    chk("returned", {rs, sh[7:0]}, rd);
    give_verdict;
  end
endmodule
